/* rtl/tfr_pkg.sv */
// Constants and types shared by the temperature fault response block
package tfr_pkg;
  // ****************************************************************
  // Command codes and defaults
  // ****************************************************************
  localparam int NCH = 2;
  localparam logic [7:0] CMD_EXT_OT = 8'h50;
  localparam logic [7:0] CMD_EXT_UT = 8'h54;
  localparam logic [7:0] CMD_INT_OT = 8'hD6;
  localparam logic [7:0] DEF_EXT = 8'hB8;
  localparam logic [7:0] DEF_INT = 8'hC0;
  localparam logic [7:0] RD_NONE = 8'h00;
  // ****************************************************************
  // Response byte fields
  // ****************************************************************
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam logic [1:0] RESP_GO = 2'h0;
  localparam logic [1:0] RESP_SHUT = 2'h2;
  localparam logic [1:0] RESP_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_ON = 4'h1,
    ST_LATCH = 4'h2,
    ST_RETRY = 4'h4,
    ST_HOLD = 4'h8
  } tfr_state_t;
  typedef struct packed {
    logic [NCH-1:0] temp_ot;
    logic [NCH-1:0] temp_ut;
    logic [NCH-1:0] temp_any;
    logic none_above;
    logic mfr;
    logic mfr_ot;
  } tfr_status_t;
endpackage

/* rtl/tfr_retry_timer.sv */
// Retry interval timer for one output channel
`timescale 1ns/1ps
`default_nettype none
module tfr_retry_timer #(
  parameter int W = 16
) (
  input wire logic I_CLOCK, // System clock
  input wire logic I_RST_N, // Synchronous reset, active low
  input wire logic i_start, // Load the interval
  input wire logic [W-1:0] i_interval, // Interval in cycles, zero acts as one
  output logic o_done // One-cycle pulse when the interval ends
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic done;
  logic next_done;

  // Count down; a zero interval still waits one cycle
  always_comb
  begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (i_start)
      next_cnt = (i_interval == '0) ? W'(1) : i_interval;
    else if (cnt != '0)
    begin
      next_cnt = cnt - W'(1);
      next_done = (cnt == W'(1));
    end
  end

  // Registers only
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign o_done = done;
endmodule
`default_nettype wire

/* rtl/tfr_core.sv */
// Temperature fault response: settings, fault bits, alert and output control
`timescale 1ns/1ps
`default_nettype none
module tfr_core #(
  parameter int RW = 16
) (
  input wire logic I_CLOCK, // 100 MHz clock
  input wire logic I_RST_N, // Synchronous reset, active low
  input wire logic i_CMD_WR, // Write strobe, one cycle
  input wire logic i_CMD_RD, // Read strobe, one cycle
  input wire logic [7:0] i_CMD_CODE, // Command code
  input wire logic [7:0] i_CMD_DATA, // Write data byte
  input wire logic i_PAGE, // Selected page for paged codes
  input wire logic i_CLEAR_FAULTS, // Clear-faults command pulse
  input wire logic [tfr_pkg::NCH-1:0] i_RUN, // Channel commanded on
  input wire logic i_INT_OT, // Die overtemperature present
  input wire logic [tfr_pkg::NCH-1:0] i_EXT_OT, // External overtemperature present
  input wire logic [tfr_pkg::NCH-1:0] i_EXT_UT, // External undertemperature present
  input wire tfr_pkg::tfr_status_t i_ALERT_MASK, // High bit masks that alert source
  input wire logic [RW-1:0] i_RETRY_INTERVAL, // Retry interval in cycles
  output logic [7:0] o_RD_DATA, // Read data, valid after read strobe
  output logic o_CML_FAULT, // Rejected write, one-cycle pulse
  output tfr_pkg::tfr_status_t o_STATUS, // Latched fault bits
  output logic o_ALERT, // Alert to host, active high
  output logic [tfr_pkg::NCH-1:0] o_OUT_EN // Output enable per channel
);
  localparam int NCH = tfr_pkg::NCH;

  // ****************************************************************
  // Response settings and command port
  // ****************************************************************
  logic [7:0] ext_ot [NCH];
  logic [7:0] ext_ut [NCH];
  logic [7:0] int_ot;
  logic [7:0] next_ext_ot [NCH];
  logic [7:0] next_ext_ut [NCH];
  logic [7:0] next_int_ot;
  logic [7:0] next_rd;
  logic next_cml;
  logic int_ok;
  logic ext_ok;
  localparam int RESP_HI_C = tfr_pkg::RESP_HI;
  localparam int RESP_LO_C = tfr_pkg::RESP_LO;
  localparam int RETRY_HI_C = tfr_pkg::RETRY_HI;
  localparam int RETRY_LO_C = tfr_pkg::RETRY_LO;

  // Check and store writes; a bad byte raises CML and is dropped
  always_comb
  begin
    next_ext_ot = ext_ot;
    next_ext_ut = ext_ut;
    next_int_ot = int_ot;
    next_cml = 1'b0;
    next_rd = o_RD_DATA;
    int_ok = i_CMD_DATA[RESP_HI_C] && (i_CMD_DATA[RETRY_HI_C:RETRY_LO_C] == tfr_pkg::RETRY_NONE);
    ext_ok = !i_CMD_DATA[RESP_LO_C];
    if (i_CMD_WR)
    begin
      case (i_CMD_CODE)
        tfr_pkg::CMD_INT_OT:
        begin
          if (int_ok)
            next_int_ot = i_CMD_DATA; // Delay bits stored but never used
          next_cml = !int_ok;
        end
        tfr_pkg::CMD_EXT_OT:
        begin
          if (ext_ok)
            next_ext_ot[i_PAGE] = i_CMD_DATA;
          next_cml = !ext_ok;
        end
        tfr_pkg::CMD_EXT_UT:
        begin
          if (ext_ok)
            next_ext_ut[i_PAGE] = i_CMD_DATA;
          next_cml = !ext_ok;
        end
        default: next_cml = 1'b0;
      endcase
    end
    if (i_CMD_RD)
    begin
      case (i_CMD_CODE)
        tfr_pkg::CMD_INT_OT: next_rd = int_ot;
        tfr_pkg::CMD_EXT_OT: next_rd = ext_ot[i_PAGE];
        tfr_pkg::CMD_EXT_UT: next_rd = ext_ut[i_PAGE];
        default: next_rd = tfr_pkg::RD_NONE;
      endcase
    end
  end

  // Settings come back to defaults at power-up
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      ext_ot <= '{default: tfr_pkg::DEF_EXT};
      ext_ut <= '{default: tfr_pkg::DEF_EXT};
      int_ot <= tfr_pkg::DEF_INT;
      o_RD_DATA <= tfr_pkg::RD_NONE;
      o_CML_FAULT <= 1'b0;
    end
    else
    begin
      ext_ot <= next_ext_ot;
      ext_ut <= next_ext_ut;
      int_ot <= next_int_ot;
      o_RD_DATA <= next_rd;
      o_CML_FAULT <= next_cml;
    end
  end

  // ****************************************************************
  // Fault bits and alert
  // ****************************************************************
  logic [NCH-1:0] run_q;
  logic [NCH-1:0] run_rise;
  logic [NCH-1:0] clr;
  tfr_pkg::tfr_status_t next_status;
  logic next_alert;

  assign run_rise = i_RUN & ~run_q;
  assign clr = {NCH{i_CLEAR_FAULTS}} | run_rise;

  // Set wins over clear so a fault in the clearing cycle survives
  always_comb
  begin
    next_status.temp_ot = i_EXT_OT | (o_STATUS.temp_ot & ~clr);
    next_status.temp_ut = i_EXT_UT | (o_STATUS.temp_ut & ~clr);
    next_status.temp_any = next_status.temp_ot | next_status.temp_ut;
    next_status.mfr_ot = i_INT_OT | (o_STATUS.mfr_ot & ~(|clr));
    next_status.none_above = next_status.mfr_ot;
    next_status.mfr = next_status.mfr_ot;
    next_alert = |(next_status & ~i_ALERT_MASK);
  end

  // Registers only
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      o_STATUS <= '0;
      o_ALERT <= 1'b0;
      run_q <= '0;
    end
    else
    begin
      o_STATUS <= next_status;
      o_ALERT <= next_alert;
      run_q <= i_RUN;
    end
  end

  // ****************************************************************
  // Output control per channel
  // ****************************************************************
  tfr_pkg::tfr_state_t st [NCH];
  logic [NCH-1:0] tmr_done;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    tfr_pkg::tfr_state_t next_st;
    logic next_en;
    logic int_shut;
    logic int_hold;
    logic ot_shut;
    logic ut_shut;
    logic ext_retry;
    logic ext_stop;

    // The die fault is unpaged, so it drives both channels alike
    always_comb
    begin
      int_shut = i_INT_OT && (int_ot[RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_SHUT);
      int_hold = i_INT_OT && (int_ot[RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_HOLD);
      ot_shut = i_EXT_OT[c] && (ext_ot[c][RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_SHUT);
      ut_shut = i_EXT_UT[c] && (ext_ut[c][RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_SHUT);
      ext_stop = (ot_shut && (ext_ot[c][RETRY_HI_C:RETRY_LO_C] != tfr_pkg::RETRY_FOREVER))
        || (ut_shut && (ext_ut[c][RETRY_HI_C:RETRY_LO_C] != tfr_pkg::RETRY_FOREVER)) || int_shut;
      ext_retry = ot_shut || ut_shut;
      next_st = st[c];
      if (!i_RUN[c])
        next_st = tfr_pkg::ST_ON; // Commanded off ends retries
      else
      begin
        case (st[c])
          tfr_pkg::ST_ON:
          begin
            if (ext_stop)
              next_st = tfr_pkg::ST_LATCH;
            else if (ext_retry)
              next_st = tfr_pkg::ST_RETRY;
            else if (int_hold)
              next_st = tfr_pkg::ST_HOLD;
          end
          tfr_pkg::ST_LATCH:
            if (clr[c] && !ext_stop)
              next_st = tfr_pkg::ST_ON; // No one-cycle glitch on if cleared mid-fault
          tfr_pkg::ST_RETRY:
          begin
            if (ext_stop)
              next_st = tfr_pkg::ST_LATCH; // A non-retrying fault ends retries
            else if (tmr_done[c])
              next_st = tfr_pkg::ST_ON;
          end
          tfr_pkg::ST_HOLD:
          begin
            if (ext_stop)
              next_st = tfr_pkg::ST_LATCH;
            else if (!i_INT_OT)
              next_st = tfr_pkg::ST_ON;
          end
          default: next_st = tfr_pkg::ST_ON;
        endcase
      end
      next_en = i_RUN[c] && (next_st == tfr_pkg::ST_ON);
    end

    // Registers only
    always_ff @(posedge I_CLOCK)
    begin
      if (!I_RST_N)
      begin
        st[c] <= tfr_pkg::ST_ON;
        o_OUT_EN[c] <= 1'b0;
      end
      else
      begin
        st[c] <= next_st;
        o_OUT_EN[c] <= next_en;
      end
    end

    // Retry spacing, restarted on each entry to the wait
    tfr_retry_timer #(.W(RW)) u_tmr (
      .I_CLOCK(I_CLOCK),
      .I_RST_N(I_RST_N),
      .i_start((st[c] != tfr_pkg::ST_RETRY) && (next_st == tfr_pkg::ST_RETRY)),
      .i_interval(i_RETRY_INTERVAL),
      .o_done(tmr_done[c])
    );
  end

  // ****************************************************************
  // Assertions on channel 0, the settings and the status bits
  // ****************************************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_int_shut;
    i_RUN[0] && run_q[0] && i_INT_OT && (int_ot[RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_SHUT);
  endsequence
  sequence s_latched;
    (st[0] == tfr_pkg::ST_LATCH) && i_RUN[0] && !i_CLEAR_FAULTS && run_q[0];
  endsequence

  property p_int_def;
    @(posedge I_CLOCK) disable iff (1'b0) !I_RST_N |=> (int_ot == tfr_pkg::DEF_INT);
  endproperty
  a_int_def: assert property (p_int_def) else $error("internal default wrong");
  property p_ext_def;
    @(posedge I_CLOCK) disable iff (1'b0) !I_RST_N |=> (ext_ot[0] == tfr_pkg::DEF_EXT) && (ext_ut[1] == tfr_pkg::DEF_EXT);
  endproperty
  a_ext_def: assert property (p_ext_def) else $error("external default wrong");
  property p_int_bad_resp;
    i_CMD_WR && (i_CMD_CODE == tfr_pkg::CMD_INT_OT) && !i_CMD_DATA[RESP_HI_C] |=> o_CML_FAULT && $stable(int_ot);
  endproperty
  a_int_bad_resp: assert property (p_int_bad_resp) else $error("bad response not rejected");
  property p_int_bad_retry;
    i_CMD_WR && (i_CMD_CODE == tfr_pkg::CMD_INT_OT)
      && (i_CMD_DATA[RETRY_HI_C:RETRY_LO_C] != tfr_pkg::RETRY_NONE) |=> o_CML_FAULT;
  endproperty
  a_int_bad_retry: assert property (p_int_bad_retry) else $error("bad retry not rejected");
  property p_delay_ignored;
    i_CMD_WR && (i_CMD_CODE == tfr_pkg::CMD_INT_OT) && (i_CMD_DATA[RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_HOLD)
      && (i_CMD_DATA[RETRY_HI_C:RETRY_LO_C] == tfr_pkg::RETRY_NONE) |=> !o_CML_FAULT;
  endproperty
  a_delay_ignored: assert property (p_delay_ignored) else $error("delay bits rejected");
  property p_shut;
    s_int_shut |=> !o_OUT_EN[0] ##1 !o_OUT_EN[0];
  endproperty
  a_shut: assert property (p_shut) else $error("output not shut");
  property p_hold_resume;
    (st[0] == tfr_pkg::ST_HOLD) && i_RUN[0] && !i_INT_OT && (int_ot[RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_HOLD)
      && !i_EXT_OT[0] && !i_EXT_UT[0] |=> o_OUT_EN[0];
  endproperty
  a_hold_resume: assert property (p_hold_resume) else $error("no resume");
  property p_latched;
    s_latched |=> !o_OUT_EN[0];
  endproperty
  a_latched: assert property (p_latched) else $error("latched output enabled");
  property p_alert;
    i_EXT_OT[0] && !i_ALERT_MASK.temp_ot[0] |=> o_ALERT && o_STATUS.temp_ot[0] && o_STATUS.temp_any[0];
  endproperty
  a_alert: assert property (p_alert) else $error("no alert on fault");
  property p_int_bits;
    i_INT_OT |=> o_STATUS.none_above && o_STATUS.mfr && o_STATUS.mfr_ot;
  endproperty
  a_int_bits: assert property (p_int_bits) else $error("internal bits missing");
  property p_clear;
    i_CLEAR_FAULTS && !i_INT_OT && !(|i_EXT_OT) && !(|i_EXT_UT) |=> (o_STATUS == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("bits not cleared");
  property p_ut;
    i_EXT_UT[1] |=> o_STATUS.temp_ut[1] && o_STATUS.temp_any[1];
  endproperty
  a_ut: assert property (p_ut) else $error("undertemp bits missing");
  property p_ext_go;
    (st[0] == tfr_pkg::ST_ON) && i_RUN[0] && run_q[0] && i_EXT_OT[0]
      && (ext_ot[0][RESP_HI_C:RESP_LO_C] == tfr_pkg::RESP_GO)
      && !i_EXT_UT[0] && !i_INT_OT |=> o_OUT_EN[0];
  endproperty
  a_ext_go: assert property (p_ext_go) else $error("code 00 stopped output");
  property p_retry_off;
    (st[0] == tfr_pkg::ST_RETRY) && !tmr_done[0] |-> !o_OUT_EN[0];
  endproperty
  a_retry_off: assert property (p_retry_off) else $error("on during retry wait");
endmodule
`default_nettype wire

/* bench/tfr_host_model.sv */
// Host model that drives the command port of the temperature fault block
`timescale 1ns/1ps
`default_nettype none
module tfr_host_model (
  input wire logic I_CLOCK, // System clock
  input wire logic [7:0] i_rd_data, // Read data from the block
  input wire logic i_cml, // Rejected write pulse
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic [7:0] o_code, // Command code
  output logic [7:0] o_data, // Write byte
  output logic o_page, // Page select
  output logic o_clear // Clear-faults pulse
);
  // Idle bus at time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_code = 8'h00;
    o_data = 8'h00;
    o_page = 1'b0;
    o_clear = 1'b0;
  end
  // One command: drive after a falling edge, hold over the taking edge, then sample and release
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data, input logic pg,
                      output logic [7:0] rd, output logic cml);
    @(negedge I_CLOCK);
    o_wr <= wr;
    o_rd <= !wr;
    o_code <= code;
    o_data <= data;
    o_page <= pg;
    @(negedge I_CLOCK);
    rd = i_rd_data;
    cml = i_cml;
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    // Released lines change value so a stale byte cannot pass for a live one
    o_code <= ~code;
    o_data <= ~data;
    o_page <= ~pg;
  endtask
  // Clear-faults command, one cycle wide
  task automatic clear_faults();
    @(negedge I_CLOCK);
    o_clear <= 1'b1;
    @(negedge I_CLOCK);
    o_clear <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/tb_temperature_fault_response.sv */
// Self-checking testbench for the temperature fault response block
`timescale 1ns/1ps
`default_nettype none
module tb_temperature_fault_response;
  logic clk, rst_n, wr, rd, page, clr, int_ot, cml, alert;
  logic [7:0] code, data, rd_data;
  logic [1:0] run, ext_ot, ext_ut, out_en;
  logic [15:0] interval;
  tfr_pkg::tfr_status_t mask, status;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  tfr_core #(.RW(16)) dut (.I_CLOCK(clk), .I_RST_N(rst_n), .i_CMD_WR(wr), .i_CMD_RD(rd), .i_CMD_CODE(code),
    .i_CMD_DATA(data), .i_PAGE(page), .i_CLEAR_FAULTS(clr), .i_RUN(run), .i_INT_OT(int_ot), .i_EXT_OT(ext_ot),
    .i_EXT_UT(ext_ut), .i_ALERT_MASK(mask), .i_RETRY_INTERVAL(interval), .o_RD_DATA(rd_data),
    .o_CML_FAULT(cml), .o_STATUS(status), .o_ALERT(alert), .o_OUT_EN(out_en));
  tfr_host_model host (.I_CLOCK(clk), .i_rd_data(rd_data), .i_cml(cml), .o_wr(wr), .o_rd(rd),
    .o_code(code), .o_data(data), .o_page(page), .o_clear(clr));
  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_cmd(input logic [7:0] c, input logic [7:0] d, input logic pg, input logic exp_cml);
    logic [7:0] r;
    logic f;
    host.xfer(1'b1, c, d, pg, r, f);
    check({15'h0000, f}, {15'h0000, exp_cml});
  endtask
  task automatic rd_cmd(input logic [7:0] c, input logic pg, input logic [7:0] exp);
    logic [7:0] r;
    logic f;
    host.xfer(1'b0, c, 8'h00, pg, r, f);
    check({8'h00, r}, {8'h00, exp});
  endtask
  // Outputs enables, status bits and alert in one go
  task automatic expect_out(input logic [1:0] en, input logic [8:0] st, input logic al);
    check({14'h0000, out_en}, {14'h0000, en});
    check({7'h00, status}, {7'h00, st});
    check({15'h0000, alert}, {15'h0000, al});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    rd_cmd(tfr_pkg::CMD_EXT_OT, 1'b0, 8'hB8);
    rd_cmd(tfr_pkg::CMD_EXT_OT, 1'b1, 8'hB8);
    rd_cmd(tfr_pkg::CMD_EXT_UT, 1'b0, 8'hB8);
    rd_cmd(tfr_pkg::CMD_EXT_UT, 1'b1, 8'hB8);
    rd_cmd(tfr_pkg::CMD_INT_OT, 1'b0, 8'hC0);
    wr_cmd(8'h33, 8'h80, 1'b0, 1'b0);
    rd_cmd(8'h33, 1'b0, 8'h00);
  endtask
  task automatic t_writes();
    wr_cmd(tfr_pkg::CMD_INT_OT, 8'h00, 1'b0, 1'b1);
    wr_cmd(tfr_pkg::CMD_INT_OT, 8'h40, 1'b0, 1'b1);
    for (int r = 1; r < 8; r++)
      wr_cmd(tfr_pkg::CMD_INT_OT, 8'hC0 | 8'(r << 3), 1'b0, 1'b1);
    rd_cmd(tfr_pkg::CMD_INT_OT, 1'b0, 8'hC0);
    wr_cmd(tfr_pkg::CMD_EXT_OT, 8'h40, 1'b1, 1'b1);
    wr_cmd(tfr_pkg::CMD_EXT_UT, 8'hC0, 1'b1, 1'b1);
    rd_cmd(tfr_pkg::CMD_EXT_UT, 1'b1, 8'hB8);
    wr_cmd(tfr_pkg::CMD_EXT_OT, 8'h80, 1'b0, 1'b0);
    rd_cmd(tfr_pkg::CMD_EXT_OT, 1'b0, 8'h80);
    rd_cmd(tfr_pkg::CMD_EXT_OT, 1'b1, 8'hB8);
  endtask
  // Shut and latch: output stays off after the fault goes until cleared
  task automatic t_ext_latch();
    ext_ot[0] = 1'b1;
    wait_n(3);
    expect_out(2'b10, 9'h088, 1'b1);
    ext_ot[0] = 1'b0;
    wait_n(10);
    expect_out(2'b10, 9'h088, 1'b1);
    host.clear_faults();
    wait_n(3);
    expect_out(2'b11, 9'h000, 1'b0);
  endtask
  task automatic t_ext_ignore();
    wr_cmd(tfr_pkg::CMD_EXT_OT, 8'h00, 1'b0, 1'b0);
    ext_ot[0] = 1'b1;
    wait_n(3);
    expect_out(2'b11, 9'h088, 1'b1);
    ext_ot[0] = 1'b0;
    host.clear_faults();
  endtask
  // Retry forever: output comes back after the interval while the fault stays
  task automatic t_ext_retry();
    bit seen_on;
    bit seen_reshut;
    seen_on = 1'b0;
    seen_reshut = 1'b0;
    wr_cmd(tfr_pkg::CMD_EXT_OT, 8'hB8, 1'b0, 1'b0);
    ext_ot[0] = 1'b1;
    wait_n(2);
    check({14'h0000, out_en}, 16'h0002);
    for (int i = 0; i < 30; i++)
    begin
      wait_n(1);
      if (seen_on && out_en[0] === 1'b0)
        seen_reshut = 1'b1;
      if (out_en[0] === 1'b1)
        seen_on = 1'b1;
    end
    check({15'h0000, seen_on}, 16'h0001);
    check({15'h0000, seen_reshut}, 16'h0001);
    ext_ot[0] = 1'b0;
    wait_n(20);
    check({14'h0000, out_en}, 16'h0003);
    host.clear_faults();
  endtask
  // Undertemperature with and without the alert masked
  task automatic t_ext_ut();
    ext_ut[1] = 1'b1;
    wait_n(3);
    check({7'h00, status}, 16'h0050);
    check({15'h0000, alert}, 16'h0001);
    ext_ut[1] = 1'b0;
    host.clear_faults();
    mask = 9'h050;
    ext_ut[1] = 1'b1;
    wait_n(3);
    check({7'h00, status}, 16'h0050);
    check({15'h0000, alert}, 16'h0000);
    ext_ut[1] = 1'b0;
    host.clear_faults();
    mask = 9'h000;
    wait_n(30);
  endtask
  // Die fault: hold mode, then shut-and-latch mode with the delay field ignored
  task automatic t_internal();
    int_ot = 1'b1;
    wait_n(3);
    expect_out(2'b00, 9'h007, 1'b1);
    int_ot = 1'b0;
    wait_n(5);
    expect_out(2'b11, 9'h007, 1'b1);
    run = 2'b10;
    wait_n(2);
    run = 2'b11;
    wait_n(3);
    expect_out(2'b11, 9'h000, 1'b0);
    wr_cmd(tfr_pkg::CMD_INT_OT, 8'h87, 1'b0, 1'b0);
    rd_cmd(tfr_pkg::CMD_INT_OT, 1'b0, 8'h87);
    int_ot = 1'b1;
    wait_n(2);
    int_ot = 1'b0;
    wait_n(10);
    expect_out(2'b00, 9'h007, 1'b1);
    host.clear_faults();
    wait_n(3);
    expect_out(2'b11, 9'h000, 1'b0);
    // Hold code with delay bits set is still accepted and kept as written
    wr_cmd(tfr_pkg::CMD_INT_OT, 8'hC5, 1'b0, 1'b0);
    rd_cmd(tfr_pkg::CMD_INT_OT, 1'b0, 8'hC5);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst_n = 1'b0;
    run = 2'b00;
    int_ot = 1'b0;
    ext_ot = 2'b00;
    ext_ut = 2'b00;
    mask = 9'h000;
    interval = 16'h0004;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    expect_out(2'b00, 9'h000, 1'b0);
    run = 2'b11;
    wait_n(3);
    check({14'h0000, out_en}, 16'h0003);
    t_defaults();
    t_writes();
    t_ext_latch();
    t_ext_ignore();
    t_ext_retry();
    t_ext_ut();
    t_internal();
    print_verdict();
  end
endmodule
`default_nettype wire
